// ### rtl/fbo_flash_host.sv
// Host-side controller that drives a parallel flash through its bus pins
`timescale 1ns/1ps
module fbo_flash_host (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User command port
  input wire logic cmdValid,
  output logic cmdReady,
  input wire fbo_pkg::fbo_op_t cmdOp,
  input wire logic cmdWordMode,
  input wire logic [fbo_pkg::UADDR_W-1:0] cmdAddr,
  input wire logic [fbo_pkg::DATA_W-1:0] cmdData,
  output logic cmdDone,
  output logic [fbo_pkg::DATA_W-1:0] cmdRdata,
  // Flash control pins
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic flashResetN,
  output logic highVoltageLevel,
  output logic flashByteN,
  output logic [fbo_pkg::ADDR_W-1:0] wordAddressBus,
  // Flash data pins
  output logic [7:0] lowDataLaneO,
  output logic lowDataLaneOe,
  input wire logic [7:0] lowDataLaneI,
  output logic [6:0] highDataLaneO,
  output logic highDataLaneOe,
  input wire logic [6:0] highDataLaneI,
  output logic topDataOrLowAddrO,
  output logic topDataOrLowAddrOe,
  input wire logic topDataOrLowAddrI
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    fbo_pkg::fbo_state_t st;                 // Sequencer state
    logic [fbo_pkg::CNT_W-1:0] cnt;          // Timing counter
    logic ceN, oeN, weN, rstN, vidEn, byteN; // Control pins
    logic [fbo_pkg::ADDR_W-1:0] addr;        // Address pins
    logic [fbo_pkg::DATA_W-1:0] dq;          // Data pins out
    logic lowOe, highOe, topOe;              // Lane enables
    logic tempUnp;                           // Temporary unprotect held
    logic prot;                              // Current write is a protect write
    logic ready, done;                       // Handshake
    logic [fbo_pkg::DATA_W-1:0] rdata;       // Read result
  } fbo_regs_t;

  // Reset image: standby, width select high, nothing driven
  localparam fbo_regs_t REGS_RESET = '{
    st: fbo_pkg::ST_IDLE, cnt: 4'h0, ceN: 1'b1, oeN: 1'b1, weN: 1'b1,
    rstN: 1'b1, vidEn: 1'b0, byteN: 1'b1, addr: 17'h00000, dq: 16'h0000,
    lowOe: 1'b0, highOe: 1'b0, topOe: 1'b0, tempUnp: 1'b0, prot: 1'b0,
    ready: 1'b1, done: 1'b0, rdata: 16'h0000};

  fbo_regs_t r_ff;   // Registered state
  fbo_regs_t nxt_r;  // Next state
  logic [fbo_pkg::DATA_W-1:0] pinSettled; // Synchronised data pins

  ////////////////////////////////////////////////////////////////////////////
  // Word address from the user address; byte mode drops the low bit
  function automatic logic [fbo_pkg::ADDR_W-1:0] pinAddr(
    input logic [fbo_pkg::UADDR_W-1:0] a, input logic wordMode);
    pinAddr = wordMode ? a[fbo_pkg::ADDR_W-1:0] : a[fbo_pkg::UADDR_W-1:1];
  endfunction : pinAddr

  ////////////////////////////////////////////////////////////////////////////
  // Data pins pass the synchroniser before use
  fbo_pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pinIn({topDataOrLowAddrI, highDataLaneI, lowDataLaneI}),
    .pinSettled(pinSettled)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    case (r_ff.st)
      fbo_pkg::ST_IDLE: begin
        if (cmdValid) begin
          nxt_r.ready = 1'b0;
          nxt_r.prot = 1'b0;
          nxt_r.byteN = cmdWordMode;
          nxt_r.addr = pinAddr(cmdAddr, cmdWordMode);
          nxt_r.dq = cmdData;
          // Byte mode: top pin carries the low address bit, driven whenever the flash is selected
          if (!cmdWordMode) begin
            nxt_r.dq[fbo_pkg::TOP_BIT] = cmdAddr[0];
          end
          case (cmdOp)
            fbo_pkg::OP_READ: begin
              // Flash drives data; we keep data lanes released
              nxt_r.ceN = 1'b0;
              nxt_r.oeN = 1'b0;
              nxt_r.topOe = !cmdWordMode;
              nxt_r.cnt = fbo_pkg::TACC_CYC;
              nxt_r.st = fbo_pkg::ST_RD_WAIT;
            end
            fbo_pkg::OP_WRITE: begin
              // Command, program data, erase and fast program cycles alike
              nxt_r.st = fbo_pkg::ST_WR_SETUP;
            end
            fbo_pkg::OP_PROTECT, fbo_pkg::OP_UNPROTECT: begin
              nxt_r.prot = 1'b1;
              nxt_r.vidEn = 1'b1;
              nxt_r.addr[fbo_pkg::ADDR_BIT_SIX] = (cmdOp == fbo_pkg::OP_UNPROTECT);
              nxt_r.addr[fbo_pkg::ADDR_BIT_ONE] = 1'b1;
              nxt_r.addr[fbo_pkg::ADDR_BIT_ZERO] = 1'b0;
              nxt_r.cnt = fbo_pkg::TVID_CYC;
              nxt_r.st = fbo_pkg::ST_VID_RISE;
            end
            fbo_pkg::OP_RESET: begin
              nxt_r.rstN = 1'b0;
              nxt_r.vidEn = 1'b0;
              nxt_r.cnt = fbo_pkg::TRP_CYC;
              nxt_r.st = fbo_pkg::ST_RST_LOW;
            end
            fbo_pkg::OP_TEMP_ON: begin
              nxt_r.vidEn = 1'b1;
              nxt_r.tempUnp = 1'b1;
              nxt_r.st = fbo_pkg::ST_FINISH;
            end
            default: begin
              nxt_r.vidEn = 1'b0;
              nxt_r.tempUnp = 1'b0;
              nxt_r.st = fbo_pkg::ST_FINISH;
            end
          endcase
        end
      end
      fbo_pkg::ST_RD_WAIT: begin
        // Wait access time plus synchroniser latency, then sample
        if (r_ff.cnt == fbo_pkg::CNT_ZERO) begin
          nxt_r.rdata = r_ff.byteN ? pinSettled : {8'h00, pinSettled[7:0]};
          nxt_r.oeN = 1'b1;
          nxt_r.ceN = 1'b1;
          nxt_r.topOe = 1'b0;
          nxt_r.st = fbo_pkg::ST_FINISH;
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      fbo_pkg::ST_VID_RISE: begin
        // Let the high voltage settle before the protect write
        if (r_ff.cnt == fbo_pkg::CNT_ZERO) begin
          nxt_r.st = fbo_pkg::ST_WR_SETUP;
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      fbo_pkg::ST_WR_SETUP: begin
        // Select, strobe and data start together; address and data are already steady
        nxt_r.ceN = 1'b0;
        nxt_r.lowOe = 1'b1;
        nxt_r.highOe = r_ff.byteN;
        nxt_r.topOe = 1'b1;
        nxt_r.weN = 1'b0;
        nxt_r.cnt = fbo_pkg::TWP_CYC;
        nxt_r.st = fbo_pkg::ST_WR_PULSE;
      end
      fbo_pkg::ST_WR_PULSE: begin
        // Strobe rises first, so data is latched before select rises
        if (r_ff.cnt == fbo_pkg::CNT_ZERO) begin
          nxt_r.weN = 1'b1;
          nxt_r.st = fbo_pkg::ST_WR_HOLD;
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      fbo_pkg::ST_WR_HOLD: begin
        nxt_r.ceN = 1'b1;
        nxt_r.lowOe = 1'b0;
        nxt_r.highOe = 1'b0;
        nxt_r.topOe = 1'b0;
        nxt_r.vidEn = r_ff.tempUnp; // Protect voltage drops unless held
        nxt_r.st = fbo_pkg::ST_FINISH;
      end
      fbo_pkg::ST_RST_LOW: begin
        if (r_ff.cnt == fbo_pkg::CNT_ZERO) begin
          nxt_r.rstN = 1'b1;
          nxt_r.cnt = fbo_pkg::TRH_CYC;
          nxt_r.st = fbo_pkg::ST_RST_REC;
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      fbo_pkg::ST_RST_REC: begin
        // No bus cycle until the flash has recovered
        if (r_ff.cnt == fbo_pkg::CNT_ZERO) begin
          nxt_r.vidEn = r_ff.tempUnp;
          nxt_r.st = fbo_pkg::ST_FINISH;
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      fbo_pkg::ST_FINISH: begin
        nxt_r.done = 1'b1;
        nxt_r.ready = 1'b1;
        nxt_r.st = fbo_pkg::ST_IDLE;
      end
      default: begin
        nxt_r = REGS_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_ff <= REGS_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign cmdReady = r_ff.ready;
  assign cmdDone = r_ff.done;
  assign cmdRdata = r_ff.rdata;
  assign flashCeN = r_ff.ceN;
  assign flashOeN = r_ff.oeN;
  assign flashWeN = r_ff.weN;
  assign flashResetN = r_ff.rstN;
  assign highVoltageLevel = r_ff.vidEn;
  assign flashByteN = r_ff.byteN;
  assign wordAddressBus = r_ff.addr;
  assign lowDataLaneO = r_ff.dq[7:0];
  assign lowDataLaneOe = r_ff.lowOe;
  assign highDataLaneO = r_ff.dq[14:8];
  assign highDataLaneOe = r_ff.highOe;
  assign topDataOrLowAddrO = r_ff.dq[fbo_pkg::TOP_BIT];
  assign topDataOrLowAddrOe = r_ff.topOe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_read_strobe_high: assert property (!r_ff.oeN |-> r_ff.weN && !r_ff.ceN)
    else $error("Output gate low while strobe low or deselected");
  chk_write_gate_high: assert property (!r_ff.weN |-> r_ff.oeN && !r_ff.ceN)
    else $error("Write strobe low without select or with gate low");
  chk_no_contention: assert property (!r_ff.oeN |-> !r_ff.lowOe && !r_ff.highOe)
    else $error("Host drives data while flash output is gated on");
  chk_byte_high_float: assert property (!r_ff.byteN |-> !r_ff.highOe)
    else $error("High lane driven in byte mode");
  chk_top_addr_drive: assert property (!r_ff.byteN && !r_ff.ceN |-> r_ff.topOe)
    else $error("Top pin not driven as address in byte mode");
  chk_addr_steady: assert property (!r_ff.weN |->
    $stable(r_ff.addr) && $stable(r_ff.dq))
    else $error("Address or data moved during write strobe");
  chk_reset_length: assert property ($fell(r_ff.rstN) |-> !r_ff.rstN [*8])
    else $error("Reset pulse too short");
  chk_reset_quiet: assert property (!r_ff.rstN |-> r_ff.ceN && r_ff.oeN && r_ff.weN)
    else $error("Bus cycle during reset");
  chk_protect_bits: assert property ((r_ff.prot && !r_ff.weN) |->
    r_ff.vidEn && r_ff.addr[fbo_pkg::ADDR_BIT_ONE] && !r_ff.addr[fbo_pkg::ADDR_BIT_ZERO])
    else $error("Protect write without required levels");
  chk_idle_standby: assert property (r_ff.st == fbo_pkg::ST_IDLE |-> r_ff.ceN)
    else $error("Select low while idle");
  chk_read_done: assert property ((cmdValid && r_ff.ready && cmdOp == fbo_pkg::OP_READ)
    |-> ##[2:20] r_ff.done)
    else $error("Read did not complete in time");

  cov_read: cover property (r_ff.st == fbo_pkg::ST_RD_WAIT ##1 r_ff.done);
  cov_write: cover property ($rose(r_ff.weN) && !r_ff.prot);
  cov_protect: cover property ($rose(r_ff.weN) && r_ff.prot);
  cov_reset: cover property ($rose(r_ff.rstN));

endmodule : fbo_flash_host

// ### rtl/fbo_pin_sync.sv
// Three-stage synchroniser for the data pins read back from the flash
`timescale 1ns/1ps
module fbo_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Raw pins and settled value
  input wire logic [fbo_pkg::DATA_W-1:0] pinIn,
  output logic [fbo_pkg::DATA_W-1:0] pinSettled
);

  ////////////////////////////////////////////////////////////////////////////
  // One chain per bit; a bit changes once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < fbo_pkg::DATA_W; i++) begin : g_bit
      logic s1_ff;  // Metastability catcher, read only by s2
      logic s2_ff;  // Second stage
      logic s3_ff;  // Third stage
      logic out_ff; // Settled output
      // Shift chain and agreement filter
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          out_ff <= 1'b0;
        end else begin
          s1_ff <= pinIn[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            out_ff <= s3_ff;
          end
        end
      end
      assign pinSettled[i] = out_ff;
    end
  endgenerate

endmodule : fbo_pin_sync

// ### rtl/fbo_pkg.sv
// Shared constants and types for the parallel flash bus host controller
package fbo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 17;            // Word address pins
  localparam int UADDR_W = 18;           // User byte address
  localparam int DATA_W = 16;            // Full data bus
  localparam int CNT_W = 4;              // Timing counter width

  ////////////////////////////////////////////////////////////////////////////
  // Address bit positions used by sector protect writes
  localparam int ADDR_BIT_SIX = 6;
  localparam int ADDR_BIT_ONE = 1;
  localparam int ADDR_BIT_ZERO = 0;
  localparam int TOP_BIT = 15;           // Top data pin index

  ////////////////////////////////////////////////////////////////////////////
  // Timing, in nanoseconds, and derived cycle counts at the system clock
  localparam int CLK_PERIOD_NS = 40;     // 25 MHz clock
  localparam int TACC_NS = 120;          // Read access time allowed
  localparam int TWP_NS = 50;            // Write strobe low time
  localparam int TRP_NS = 500;           // Reset pin low time
  localparam int TRH_NS = 50;            // Recovery after reset release
  localparam int TVID_NS = 500;          // Settle time of the high voltage
  localparam int SYNC_LAT = 4;           // Pin synchroniser latency in cycles

  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] TACC_CYC =
    CNT_W'((TACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
  localparam logic [CNT_W-1:0] TWP_CYC =
    CNT_W'((TWP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TRP_CYC =
    CNT_W'((TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TRH_CYC =
    CNT_W'((TRH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TVID_CYC =
    CNT_W'((TVID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // User operations
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RESET = 3'h2,
    OP_PROTECT = 3'h3,
    OP_UNPROTECT = 3'h4,
    OP_TEMP_ON = 3'h5,
    OP_TEMP_OFF = 3'h6
  } fbo_op_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_WAIT = 4'h1,
    ST_WR_SETUP = 4'h2,
    ST_WR_PULSE = 4'h3,
    ST_WR_HOLD = 4'h4,
    ST_RST_LOW = 4'h5,
    ST_RST_REC = 4'h6,
    ST_VID_RISE = 4'h7,
    ST_FINISH = 4'h8
  } fbo_state_t;

endpackage : fbo_pkg

// ### verif/fbo_flash_model.sv
// Behavioural parallel flash device facing the host controller pins
`timescale 1ns/1ps
module fbo_flash_model (
  // Control pins
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic resetN,
  input wire logic highV,
  input wire logic byteN,
  input wire logic [16:0] addr,
  // Host drive of the data pins
  input wire logic [15:0] hostO,
  input wire logic hostLowOe,
  input wire logic hostHighOe,
  input wire logic hostTopOe,
  // Resolved data pins
  output logic [15:0] pinV
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] lastV = 16'h0000; // Last driven level, shown inverted when released
  logic [15:0] drvV; // Driven values
  logic [15:0] drvM; // Driven bit mask
  logic [15:0] wordV; // Array word at the address pins
  logic [7:0] byteV; // Array byte picked by the low address bit
  logic topIn; // Level on the top pin as seen by the array
  logic rstActive; // Reset pin low without high voltage
  logic drive; // Array data enabled onto the pins
  logic wrLow; // Combined write strobe
  logic [17:0] latAddr = 18'h00000; // Command latch address
  logic [15:0] latData = 16'h0000; // Command latch data
  logic latHv = 1'b0; // High voltage seen at the write
  int nWrite = 0; // Write cycles accepted
  int nClash = 0; // Times both sides drove a pin
  time rstFall = 0; // Moment the reset pin fell
  time rstLow = 0; // Length of the last reset pulse

  ////////////////////////////////////////////////////////////////////////////
  // Read path, array read from power-up, never left in this model
  assign wordV = {addr[7:0] ^ 8'h5A, addr[15:8] ^ {7'h00, addr[16]}};
  assign topIn = hostTopOe ? hostO[15] : ~lastV[15]; // Low address bit in byte mode
  assign byteV = topIn ? wordV[15:8] : wordV[7:0];
  assign rstActive = !resetN && !highV;
  assign drive = !ceN && !oeN && weN && !rstActive;

  // Pin resolution from both parties
  always @* begin
    drvV = hostO;
    drvM = {hostTopOe, {7{hostHighOe}}, {8{hostLowOe}}};
    if (drive) begin
      if (byteN) begin // Word mode, every pin
        drvV = wordV;
        drvM = 16'hFFFF;
      end else begin // Byte mode, low lane only, pins 8-14 float
        drvV[7:0] = byteV;
        drvM[7:0] = 8'hFF;
      end
    end
  end

  // Remember driven bits so a released pin shows their inverse
  always @(drvV, drvM) begin
    for (int i = 0; i < 16; i++) begin
      if (drvM[i]) lastV[i] = drvV[i];
    end
  end
  assign pinV = (drvV & drvM) | (~lastV & ~drvM);

  // Contention between host and array
  always @(drive, hostLowOe, hostHighOe, hostTopOe, byteN) begin
    #1;
    if (drive && (hostLowOe || hostHighOe || (hostTopOe && byteN))) nClash++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command latches, not in the memory map
  assign wrLow = !ceN && !weN && oeN && !rstActive;
  always @(posedge wrLow) begin // Address on the later falling strobe
    #1; // Let the resolved pins settle after the strobe edge
    latAddr <= byteN ? {1'b0, addr} : {addr, pinV[15]};
    latHv <= highV;
  end
  always @(negedge wrLow) begin // Data on the earlier rising strobe
    latData <= byteN ? pinV : {8'h00, pinV[7:0]};
    nWrite <= nWrite + 1;
  end

  // Reset pulse length
  always @(negedge resetN) rstFall = $time;
  always @(posedge resetN) rstLow = $time - rstFall;
endmodule : fbo_flash_model

// ### verif/tb.sv
// Self-checking bench for the flash bus host controller
`timescale 1ns/1ps
module tb;
  ////////////////////////////////////////////////////////////////////////////
  // Signals
  logic clk, resetn, cmdValid, cmdReady, cmdWordMode, cmdDone;
  fbo_pkg::fbo_op_t cmdOp;
  logic [17:0] cmdAddr;
  logic [15:0] cmdData, cmdRdata, pinV;
  logic flashCeN, flashOeN, flashWeN, flashResetN, highVoltageLevel, flashByteN;
  logic [16:0] wordAddressBus;
  logic [7:0] lowDataLaneO;
  logic [6:0] highDataLaneO;
  logic lowDataLaneOe, highDataLaneOe, topDataOrLowAddrO, topDataOrLowAddrOe;
  int n_mismatch = 0;
  int n_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design and flash model
  fbo_flash_host DUT (.clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdWordMode(cmdWordMode), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdDone(cmdDone), .cmdRdata(cmdRdata), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .flashResetN(flashResetN), .highVoltageLevel(highVoltageLevel),
    .flashByteN(flashByteN), .wordAddressBus(wordAddressBus), .lowDataLaneO(lowDataLaneO),
    .lowDataLaneOe(lowDataLaneOe), .lowDataLaneI(pinV[7:0]), .highDataLaneO(highDataLaneO),
    .highDataLaneOe(highDataLaneOe), .highDataLaneI(pinV[14:8]),
    .topDataOrLowAddrO(topDataOrLowAddrO), .topDataOrLowAddrOe(topDataOrLowAddrOe),
    .topDataOrLowAddrI(pinV[15]));
  fbo_flash_model flash (.ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
    .resetN(flashResetN), .highV(highVoltageLevel), .byteN(flashByteN), .addr(wordAddressBus),
    .hostO({topDataOrLowAddrO, highDataLaneO, lowDataLaneO}), .hostLowOe(lowDataLaneOe),
    .hostHighOe(highDataLaneOe), .hostTopOe(topDataOrLowAddrOe), .pinV(pinV));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] patW(input logic [16:0] a);
    return {a[7:0] ^ 8'h5A, a[15:8] ^ {7'h00, a[16]}};
  endfunction : patW

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [17:0] expV, input logic [17:0] gotV);
    n_checks++;
    if (gotV !== expV) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, expV, gotV);
    end
  endtask : chk

  // One request on the command port, waiting for its done pulse
  task automatic doOp(input fbo_pkg::fbo_op_t op, input logic wm, input logic [17:0] a,
    input logic [15:0] d);
    int i;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdWordMode <= wm;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      #1;
      if (cmdDone === 1'b1) break;
    end
    if (i == 64) begin
      n_mismatch++;
      $display("[FAIL] done expected 1 seen timeout");
      give_verdict();
    end
  endtask : doOp

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_idle();
    chk("idle pins", 18'h001F1, {9'h000, flashCeN, flashOeN, flashWeN, flashResetN,
      flashByteN, lowDataLaneOe, highDataLaneOe, topDataOrLowAddrOe, cmdReady});
  endtask : s_idle

  task automatic s_readWord();
    logic [16:0] tbl [3] = '{17'h00000, 17'h1FFFF, 17'h0A5C3};
    foreach (tbl[k]) begin
      doOp(fbo_pkg::OP_READ, 1'b1, {1'b0, tbl[k]}, 16'h0000);
      chk("word read", {2'b00, patW(tbl[k])}, {2'b00, cmdRdata});
    end
  endtask : s_readWord

  task automatic s_readByte();
    logic [17:0] tbl [4] = '{18'h00000, 18'h00001, 18'h3FFFF, 18'h14B7E};
    logic [15:0] w;
    foreach (tbl[k]) begin
      w = patW(tbl[k][17:1]);
      doOp(fbo_pkg::OP_READ, 1'b0, tbl[k], 16'h0000);
      chk("byte read", {10'h000, tbl[k][0] ? w[15:8] : w[7:0]},
        {2'b00, cmdRdata});
    end
  endtask : s_readByte

  task automatic s_write();
    int n0;
    n0 = flash.nWrite;
    doOp(fbo_pkg::OP_WRITE, 1'b1, 18'h1ABCD, 16'hBEEF);
    chk("word write addr", 18'h1ABCD, flash.latAddr);
    chk("word write data", 18'h0BEEF, {2'b00, flash.latData});
    doOp(fbo_pkg::OP_WRITE, 1'b0, 18'h2D0C3, 16'h1234);
    chk("byte write addr", 18'h2D0C3, flash.latAddr);
    chk("byte write data", 18'h00034, {2'b00, flash.latData});
    chk("write count", 18'(n0 + 2), 18'(flash.nWrite));
    doOp(fbo_pkg::OP_READ, 1'b1, 18'h1ABCD, 16'h0000);
    chk("read after write", {2'b00, patW(17'h1ABCD)}, {2'b00, cmdRdata});
  endtask : s_write

  task automatic s_fastProgram();
    int n0;
    n0 = flash.nWrite;
    doOp(fbo_pkg::OP_WRITE, 1'b1, 18'h00555, 16'h00A0);
    doOp(fbo_pkg::OP_WRITE, 1'b1, 18'h04000, 16'h5AA5);
    chk("fast program writes", 18'(n0 + 2), 18'(flash.nWrite));
    chk("fast program data", 18'h05AA5, {2'b00, flash.latData});
  endtask : s_fastProgram

  task automatic s_protect();
    doOp(fbo_pkg::OP_PROTECT, 1'b1, 18'h18000, 16'h0000);
    chk("protect addr", 18'h18002, flash.latAddr);
    chk("protect high voltage", 18'h00001, {17'h00000, flash.latHv});
    doOp(fbo_pkg::OP_UNPROTECT, 1'b1, 18'h10000, 16'h0000);
    chk("unprotect addr", 18'h10042, flash.latAddr);
    chk("unprotect high voltage", 18'h00001, {17'h00000, flash.latHv});
    chk("voltage released", 18'h00000, {17'h00000, highVoltageLevel});
  endtask : s_protect

  task automatic s_resetPulse();
    doOp(fbo_pkg::OP_RESET, 1'b1, 18'h00000, 16'h0000);
    chk("reset pulse long", 18'h00001, {17'h00000, flash.rstLow >= 500});
    doOp(fbo_pkg::OP_READ, 1'b1, 18'h00777, 16'h0000);
    chk("read after reset", {2'b00, patW(17'h00777)}, {2'b00, cmdRdata});
  endtask : s_resetPulse

  task automatic s_tempUnprotect();
    doOp(fbo_pkg::OP_TEMP_ON, 1'b1, 18'h00000, 16'h0000);
    chk("temp on", 18'h00001, {17'h00000, highVoltageLevel});
    doOp(fbo_pkg::OP_WRITE, 1'b1, 18'h00100, 16'hC0DE);
    chk("temp write voltage", 18'h00001, {17'h00000, flash.latHv});
    doOp(fbo_pkg::OP_TEMP_OFF, 1'b1, 18'h00000, 16'h0000);
    chk("temp off", 18'h00000, {17'h00000, highVoltageLevel});
  endtask : s_tempUnprotect

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    resetn = 1'b0;
    cmdValid = 1'b0;
    cmdOp = fbo_pkg::OP_READ;
    cmdWordMode = 1'b1;
    cmdAddr = 18'h00000;
    cmdData = 16'h0000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    s_idle();
    s_readWord();
    s_readByte();
    s_write();
    s_fastProgram();
    s_protect();
    s_resetPulse();
    s_tempUnprotect();
    chk("bus contention", 18'h00000, 18'(flash.nClash));
    give_verdict();
  end
endmodule : tb
